// File: periodic_wake_pkg.sv
/*
  Package for the periodic wake-up timer: register offsets, field positions,
  reset values, timing constants, the control struct and the state type.
  Assumes a 20 MHz bus clock and a 32-bit Avalon-MM register bus.
*/
package periodic_wake_pkg;

  // Bus geometry
  localparam int ADDR_W = 5;  // Byte address width of the register window
  localparam int DATA_W = 32;  // Bus data width

  // Register byte offsets
  localparam logic [4:0] OFF_CONTROL = 5'h00;  // periodic_wake_control
  localparam logic [4:0] OFF_RATE = 5'h04;  // Period field
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h08;  // Sticky events, read only
  localparam logic [4:0] OFF_IRQ_CLEAR = 5'h0C;  // Write one to clear, write only
  localparam logic [4:0] OFF_IRQ_ENABLE = 5'h10;  // Event enables

  // Field positions in periodic_wake_control
  localparam int BIT_TIMEOUT_FLAG = 0;  // periodic_timeout_flag
  localparam int BIT_IRQ_ENABLE = 1;  // periodic_irq_enable
  localparam int BIT_FEATURE_ENABLE = 2;  // periodic_feature_enable
  localparam int BIT_EXT_ACCESS = 3;  // periodic_external_access_enable
  localparam int BIT_WAVE_SELECT = 4;  // periodic_external_wave_select
  localparam int BIT_CLOCK_SELECT = 7;  // periodic_clock_select

  // Field positions in the interrupt status, clear and enable registers
  localparam int BIT_EVT_TIMEOUT = 0;  // Time-out event
  localparam int EVT_W = 1;  // Number of event bits

  // Reset values
  localparam logic [15:0] RATE_RESET = 16'h0000;  // Shortest period
  localparam logic [EVT_W-1:0] EVT_RESET = 1'h0;  // No events, none enabled

  // Timing: one period unit is 0.2 ms on the autonomous clock
  localparam int CLK_PERIOD_NS = 50;  // 20 MHz bus clock
  localparam int AUTO_UNIT_NS = 200000;  // 0.2 ms per period step
  localparam int AUTO_UNIT_CYC = AUTO_UNIT_NS / CLK_PERIOD_NS;  // 4000 cycles
  localparam int BUS_UNIT_CYC = 2;  // Two bus clocks per period step
  localparam int AUTO_PULSE_CYC = AUTO_UNIT_CYC / 2;  // Half the least period
  localparam int BUS_PULSE_CYC = BUS_UNIT_CYC / 2;  // Half the least period

  // Control register contents
  typedef struct packed {
    logic clock_select;  // 0 autonomous, 1 bus clock
    logic wave_select;  // 0 pulse, 1 clock
    logic ext_access;  // Pin drive enable
    logic feature_enable;  // Timer run
    logic irq_enable;  // Flag to interrupt
  } ctrl_t;

  // Timer state, one-hot
  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

endpackage : periodic_wake_pkg

// File: periodic_wake_timer.sv
/*
  Periodic wake-up timer with an Avalon-MM register slave, a sticky
  interrupt status block and a waveform pin.
  Assumes one 20 MHz clock, an active-low asynchronous reset and a bus
  master that holds its request until waitrequest is seen low.
*/
// Chosen here: the register offsets and the Avalon-MM slave port.
// Functional notes
// RULE1: Timer stopped while feature enable is low
// RULE2: Interrupt request when flag and enable set
// RULE3: Flag set when the period has elapsed
// RULE4: Flag cleared only by writing one
// RULE5: Autonomous clock period is (value+1)*0.2 ms
// RULE6: Bus clock period is 2*(value+1) clocks
// RULE7: Clock select writable only while feature disabled
// RULE8: Pin driven only with access and feature enabled
// RULE9: Pulse per period, or clock at double period
// RULE10: Count restarts after every time-out
`timescale 1ns/1ns
module periodic_wake_timer #(
  parameter int AUTO_UNIT = periodic_wake_pkg::AUTO_UNIT_CYC,  // Cycles per 0.2 ms step
  parameter int RATE_W = 16  // Width of the period field
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [periodic_wake_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [periodic_wake_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [periodic_wake_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic periodic_wave_output_pin,
  output logic periodic_wave_output_oe
);
  import periodic_wake_pkg::*;

  // Width of the unit prescaler and the pulse counter
  localparam int PRE_W = $clog2(AUTO_UNIT + 1);

  // Prescaler reload values at prescaler width
  localparam logic [PRE_W-1:0] AUTO_LAST = PRE_W'(AUTO_UNIT - 1);  // Autonomous step end
  localparam logic [PRE_W-1:0] BUS_LAST = PRE_W'(BUS_UNIT_CYC - 1);  // Bus step end
  localparam logic [PRE_W-1:0] AUTO_PULSE = PRE_W'(AUTO_UNIT / 2);  // Autonomous pulse
  localparam logic [PRE_W-1:0] BUS_PULSE = PRE_W'(BUS_PULSE_CYC);  // Bus pulse

  // Registers
  ctrl_t ctrl_ff;  // Control bits
  logic flag_ff;  // Time-out flag
  logic [RATE_W-1:0] rate_ff;  // Period field
  logic [EVT_W-1:0] evt_status_ff;  // Sticky event bits
  logic [EVT_W-1:0] evt_enable_ff;  // Event enables
  run_state_t state_ff;  // Timer state
  logic [PRE_W-1:0] pre_ff;  // Step prescaler
  logic [RATE_W-1:0] count_ff;  // Steps within the period
  logic [PRE_W-1:0] pulse_ff;  // Remaining pulse cycles
  logic wave_ff;  // Clock waveform level
  logic pin_ff;  // Registered pin level
  logic oe_ff;  // Registered pin enable
  logic ack_ff;  // Bus answer cycle
  logic [DATA_W-1:0] rdata_ff;  // Read data

  // Next values
  ctrl_t nxt_ctrl;
  logic nxt_flag;
  logic [EVT_W-1:0] nxt_evt_status;
  run_state_t nxt_state;

  // Bus decode
  wire logic req = avs_read | avs_write;  // Any request pending
  wire logic wr_go = avs_write & ack_ff;  // Write takes effect on answer edge
  wire logic sel_ctrl = avs_address == OFF_CONTROL;
  wire logic sel_rate = avs_address == OFF_RATE;
  wire logic sel_stat = avs_address == OFF_IRQ_STATUS;
  wire logic sel_clr = avs_address == OFF_IRQ_CLEAR;
  wire logic sel_en = avs_address == OFF_IRQ_ENABLE;
  wire logic wr_ctrl = wr_go & sel_ctrl & avs_byteenable[0];  // Control byte write
  wire logic wr_rate_lo = wr_go & sel_rate & avs_byteenable[0];  // Period low byte
  wire logic wr_rate_hi = wr_go & sel_rate & avs_byteenable[1];  // Period high byte
  wire logic wr_clr = wr_go & sel_clr & avs_byteenable[0];  // Event clear write
  wire logic wr_en = wr_go & sel_en & avs_byteenable[0];  // Event enable write

  // Written control bits
  wire logic w_fe = avs_writedata[BIT_FEATURE_ENABLE];
  wire logic w_flag_clr = wr_ctrl & avs_writedata[BIT_TIMEOUT_FLAG];  // Write one
  // Clock select only changes while disabled and not enabled by this write
  wire logic cs_writable = ~ctrl_ff.feature_enable & ~w_fe;  // [RULE7]

  // Timer decode
  wire logic running = state_ff == ST_RUN;
  wire logic [PRE_W-1:0] step_last = ctrl_ff.clock_select ? BUS_LAST : AUTO_LAST;  // [RULE5] [RULE6]
  wire logic step_tick = running & (pre_ff == step_last);  // One period step done
  wire logic timeout = step_tick & (count_ff == rate_ff);  // Period of rate+1 steps elapsed
  wire logic [PRE_W-1:0] pulse_len = ctrl_ff.clock_select ? BUS_PULSE : AUTO_PULSE;
  wire logic pulse_on = pulse_ff != '0;  // Pulse still high
  wire logic drive_pin = ctrl_ff.ext_access & ctrl_ff.feature_enable;  // [RULE8]
  wire logic wave_level = ctrl_ff.wave_select ? wave_ff : pulse_on;  // [RULE9]

  // Read mux, unmapped reads return zero
  wire logic [DATA_W-1:0] rd_ctrl = {24'h000000, ctrl_ff.clock_select, 2'b00,
                                     ctrl_ff.wave_select, ctrl_ff.ext_access,
                                     ctrl_ff.feature_enable, ctrl_ff.irq_enable, flag_ff};
  wire logic [DATA_W-1:0] rd_rate = DATA_W'(rate_ff);
  wire logic [DATA_W-1:0] rd_stat = DATA_W'(evt_status_ff);
  wire logic [DATA_W-1:0] rd_en = DATA_W'(evt_enable_ff);
  wire logic [DATA_W-1:0] rd_mux = sel_ctrl ? rd_ctrl :
                                   sel_rate ? rd_rate :
                                   sel_stat ? rd_stat :
                                   sel_en ? rd_en : '0;

  // Handshake: one wait cycle, answer on the following edge
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // Interrupt from the flag or any enabled sticky event
  assign irq = (flag_ff & ctrl_ff.irq_enable) | (|(evt_status_ff & evt_enable_ff));  // [RULE2]

  // Pin outputs from flip-flops
  assign periodic_wave_output_pin = pin_ff;
  assign periodic_wave_output_oe = oe_ff;

  // Control next value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.irq_enable = avs_writedata[BIT_IRQ_ENABLE];
      nxt_ctrl.feature_enable = w_fe;  // [RULE1]
      nxt_ctrl.ext_access = avs_writedata[BIT_EXT_ACCESS];
      nxt_ctrl.wave_select = avs_writedata[BIT_WAVE_SELECT];
      if (cs_writable) begin
        nxt_ctrl.clock_select = avs_writedata[BIT_CLOCK_SELECT];  // [RULE7]
      end
    end
  end

  // Flag next value, a time-out wins over a clear in the same cycle
  always_comb begin
    nxt_flag = flag_ff;
    if (w_flag_clr) begin
      nxt_flag = 1'b0;  // [RULE4]
    end
    if (timeout) begin
      nxt_flag = 1'b1;  // [RULE3]
    end
  end

  // Sticky event next value, set wins over clear
  always_comb begin
    nxt_evt_status = evt_status_ff;
    if (wr_clr) begin
      nxt_evt_status = evt_status_ff & ~avs_writedata[EVT_W-1:0];
    end
    if (timeout) begin
      nxt_evt_status[BIT_EVT_TIMEOUT] = 1'b1;
    end
  end

  // Run state follows the feature enable
  always_comb begin
    case (state_ff)
      ST_OFF: begin
        nxt_state = ctrl_ff.feature_enable ? ST_RUN : ST_OFF;  // [RULE1]
      end
      ST_RUN: begin
        nxt_state = ctrl_ff.feature_enable ? ST_RUN : ST_OFF;  // [RULE1]
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
  end

  // Bus answer and read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= rd_mux;  // Stands through the answer edge
      end
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= '0;
      flag_ff <= 1'b0;
      evt_status_ff <= EVT_RESET;
      evt_enable_ff <= EVT_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      evt_status_ff <= nxt_evt_status;
      if (wr_en) begin
        evt_enable_ff <= avs_writedata[EVT_W-1:0];
      end
    end
  end

  // Period field, one generate entry per byte lane
  for (genvar b = 0; b < RATE_W / 8; b++) begin : g_rate
    wire logic lane_wr = (b == 0) ? wr_rate_lo : wr_rate_hi;  // Lane strobe
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        rate_ff[b*8 +: 8] <= RATE_RESET[b*8 +: 8];
      end else if (lane_wr) begin
        rate_ff[b*8 +: 8] <= avs_writedata[b*8 +: 8];
      end
    end
  end

  // Timer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Step prescaler, held at zero while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_ff <= '0;
    end else if (!running || step_tick) begin
      pre_ff <= '0;  // [RULE1]
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // Step counter, restarts after each time-out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= '0;
    end else if (!running || timeout) begin
      count_ff <= '0;  // [RULE10]
    end else if (step_tick) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  // Pulse of half the least period, clock toggling at each time-out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_ff <= '0;
      wave_ff <= 1'b0;
    end else if (!running) begin
      pulse_ff <= '0;
      wave_ff <= 1'b0;
    end else if (timeout) begin
      pulse_ff <= pulse_len;  // [RULE9]
      wave_ff <= ~wave_ff;  // [RULE9]
    end else if (pulse_on) begin
      pulse_ff <= pulse_ff - 1'b1;
    end
  end

  // Registered pin drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      pin_ff <= drive_pin & wave_level;  // [RULE8]
      oe_ff <= drive_pin;  // [RULE8]
    end
  end

endmodule : periodic_wake_timer

// File: periodic_wake_props.sv
/* Port checker for the periodic wake-up timer.
   Assumes binding into periodic_wake_timer, one clock, low reset. */
`timescale 1ns/1ns
module periodic_wake_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [periodic_wake_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [periodic_wake_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [periodic_wake_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic periodic_wave_output_pin,
  input wire logic periodic_wave_output_oe
);
  import periodic_wake_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow enables, taken at accepted writes
  logic ie_ff, fe_ff, ea_ff, en_ff;
  wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Shadow update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {ie_ff, fe_ff, ea_ff, en_ff} <= 4'h0;
    end else if (wr_ok && avs_address == OFF_CONTROL) begin
      {ea_ff, fe_ff, ie_ff} <= avs_writedata[3:1];
    end else if (wr_ok && avs_address == OFF_IRQ_ENABLE) begin
      en_ff <= avs_writedata[0];
    end
  end
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait longer than one cycle");
  AST_WAIT_CAUSE: assert property (avs_waitrequest |-> avs_read || avs_write)
    else $error("wait without request");
  AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  AST_READ_ZERO: assert property (avs_read && !avs_waitrequest
    && (avs_address == OFF_IRQ_CLEAR || avs_address > OFF_IRQ_ENABLE)
    |-> avs_readdata == '0) else $error("empty place read nonzero");
  AST_PIN_IDLE: assert property (!periodic_wave_output_oe |-> !periodic_wave_output_pin)
    else $error("pin high while undriven");
  AST_OE_CAUSE: assert property (periodic_wave_output_oe |-> $past(fe_ff && ea_ff))
    else $error("pin enabled without run and access");
  AST_OE_ON: assert property (fe_ff && ea_ff && $past(fe_ff && ea_ff) |-> periodic_wave_output_oe)
    else $error("pin enable missing");
  AST_IRQ_CAUSE: assert property (irq |-> ie_ff || en_ff)
    else $error("irq without enable");
  cover property ($rose(irq));
  cover property ($rose(periodic_wave_output_oe));
  cover property (periodic_wave_output_pin ##1 !periodic_wave_output_pin);
endmodule : periodic_wake_props
bind periodic_wake_timer periodic_wake_props periodic_wake_props_i (.clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .irq, .periodic_wave_output_pin, .periodic_wave_output_oe);

// File: periodic_wake_timer_tb.sv
/* Self-checking bench for the periodic wake-up timer.
   Assumes the package and checker are compiled first. */
`timescale 1ns/1ns
module periodic_wake_timer_tb;
  import periodic_wake_pkg::*;
  localparam int U = 8;  // Shortened 0.2 ms step
  logic clk, rst_b, avs_read, avs_write, irq, pin, oe, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic [3:0] avs_byteenable;
  logic [31:0] exp_q[$];  // Expected read data
  int n_fail, total_checks, cyc, n;
  periodic_wake_timer #(.AUTO_UNIT(U)) periodic_wake_timer_i (.clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .irq, .periodic_wave_output_pin(pin), .periodic_wave_output_oe(oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Automatic: called from the read watcher and the scenario process alike
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One bus cycle; on reads d is the expected data
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    if (!wr) exp_q.push_back(d);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Cycles until irq (sel 0) or pin (sel 1) reaches lvl
  task wait_for(input int sel, input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((sel ? pin : irq) !== lvl);
  endtask : wait_for
  task report_and_stop();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Read answers checked against the oldest note
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    rnd = lfsr(32'h96317418);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, status write refused, empty places
    bus(1'b1, OFF_IRQ_STATUS, 32'h1);
    for (int a = 0; a < 8; a++) bus(1'b0, 5'(a * 4), 32'h0);
    bus(1'b1, OFF_RATE, rnd);
    bus(1'b0, OFF_RATE, {16'h0, rnd[15:0]});
    // Low lane alone: the high byte of the period must stay
    avs_byteenable <= 4'h1;
    bus(1'b1, OFF_RATE, {rnd[31:8], 8'h02});
    avs_byteenable <= 4'hF;
    bus(1'b0, OFF_RATE, {16'h0, rnd[15:8], 8'h02});
    bus(1'b1, OFF_RATE, 32'h2);
    // Autonomous clock, select refused in the enabling write
    bus(1'b1, OFF_CONTROL, 32'h8E);
    wait_for(0, 1'b1);
    check(n, 1 + 3 * U);
    bus(1'b1, OFF_CONTROL, 32'h0E);
    bus(1'b0, OFF_CONTROL, 32'h0F);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    check(n, U / 2);
    wait_for(1, 1'b1);
    check(n, 3 * U - U / 2);
    // Stop: pin and irq quiet
    bus(1'b1, OFF_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check({irq, oe, pin}, 32'h0);
    // Bus clock, clock wave, irq disabled
    bus(1'b1, OFF_CONTROL, 32'h81);
    bus(1'b0, OFF_CONTROL, 32'h80);
    bus(1'b1, OFF_CONTROL, 32'h9C);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    check(n, 6);
    check(irq, 1'b0);
    // Status path: raise, mask, clear
    bus(1'b1, OFF_CONTROL, 32'h80);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h1);
    #1;
    check(irq, 1'b1);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h0);
    #1;
    check(irq, 1'b0);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h1);
    bus(1'b1, OFF_IRQ_CLEAR, 32'h1);
    #1;
    check(irq, 1'b0);
    bus(1'b0, OFF_IRQ_STATUS, 32'h0);
    report_and_stop();
  end
endmodule : periodic_wake_timer_tb
